/* File: include/link_pkg.sv */
// shared constants for the byte-wide processor link port
// assumes both ends and the interface are compiled after this package
package link_pkg;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CTL_W      = 4;
  // control line positions in the ctl vector
  localparam int unsigned CTL_REQ    = 0;
  localparam int unsigned CTL_ACK    = 1;
  localparam int unsigned CTL_STRB   = 2;
  localparam int unsigned CTL_RDY    = 3;
  localparam logic [1:0]  LAST_BYTE  = 2'h3;
  localparam logic [1:0]  CNT_RESET  = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_TREQ  = 5'h02,
    ST_TBYTE = 5'h04,
    ST_RACK  = 5'h08,
    ST_RBYTE = 5'h10
  } link_state_e;
endpackage

/* File: include/link_if.sv */
// twelve-line link between two identical ports: four control lines and a byte bus
// assumes each end raises an enable only while it drives; an undriven line reads low
`timescale 1ns/1ps
interface link_if;
  logic [link_pkg::CTL_W-1:0]  near_ctl_out;
  logic [link_pkg::CTL_W-1:0]  near_ctl_oe;
  logic [link_pkg::BYTE_W-1:0] near_bus_out;
  logic                        near_bus_oe;
  logic [link_pkg::CTL_W-1:0]  far_ctl_out;
  logic [link_pkg::CTL_W-1:0]  far_ctl_oe;
  logic [link_pkg::BYTE_W-1:0] far_bus_out;
  logic                        far_bus_oe;
  logic [link_pkg::CTL_W-1:0]  ctl;
  logic [link_pkg::BYTE_W-1:0] bus;

  assign ctl = (near_ctl_out & near_ctl_oe) | (far_ctl_out & far_ctl_oe);
  assign bus = (near_bus_out & {link_pkg::BYTE_W{near_bus_oe}})
             | (far_bus_out & {link_pkg::BYTE_W{far_bus_oe}});

  modport near_end (output near_ctl_out, near_ctl_oe, near_bus_out, near_bus_oe,
                    input  ctl, bus);
  modport far_end  (output far_ctl_out, far_ctl_oe, far_bus_out, far_bus_oe,
                    input  ctl, bus);
endinterface

/* File: hw/link_port_near.sv */
// word queue and the near end of the processor link port
// assumes link_pkg and link_if are compiled first; the far end reuses link_fifo
// Summary of operation
// - eight-word transmit and receive queues
// - four control lines plus byte bus
// - token arbitration decides sender and timing
// - sender requests, receiver acknowledges before data
// - word sent as four bytes, reassembled
// - completed incoming word enters receive queue
// - enqueue by write, dequeue by read
`timescale 1ns/1ps
module link_fifo #(
  parameter int unsigned WIDTH = link_pkg::WORD_W,
  parameter int unsigned DEPTH = link_pkg::FIFO_DEPTH
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] idx);
    next_idx = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction

  assign in_ready_out  = (cnt_q != FULL);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_in;
      wr_d        = next_idx(wr_q);
    end
    if (pop) begin
      rd_d = next_idx(rd_q);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < int'(DEPTH); i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

module link_port_near #(
  parameter int unsigned DEPTH         = link_pkg::FIFO_DEPTH,
  parameter bit          OWNS_AT_RESET = 1'b1
) (
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  link_if.near_end                         link,
  input  wire logic                        tx_valid_in,
  input  wire logic [link_pkg::WORD_W-1:0] tx_data_in,
  output logic                             tx_ready_out,
  output logic                             rx_valid_out,
  output logic [link_pkg::WORD_W-1:0]      rx_data_out,
  input  wire logic                        rx_ready_in
);
  localparam int unsigned AS_W = link_pkg::WORD_W - link_pkg::BYTE_W;

  link_pkg::link_state_e         state_q, state_d;
  logic                          own_q, own_d, req_q, req_d, ack_q, ack_d;
  logic                          strb_q, strb_d, rdy_q, rdy_d;
  logic [1:0]                    cnt_q, cnt_d;
  logic [link_pkg::WORD_W-1:0]   word_q, word_d, tq_data, rq_data;
  logic [AS_W-1:0]               asm_q, asm_d;
  logic                          tq_valid, tq_pop, rq_push, rq_ready;
  logic                          req_in, ack_in, strb_in, rdy_in;

  assign req_in  = link.ctl[link_pkg::CTL_REQ];
  assign ack_in  = link.ctl[link_pkg::CTL_ACK];
  assign strb_in = link.ctl[link_pkg::CTL_STRB];
  assign rdy_in  = link.ctl[link_pkg::CTL_RDY];
  assign rq_data = {link.bus, asm_q};

  link_fifo #(.WIDTH(link_pkg::WORD_W), .DEPTH(DEPTH)) tx_q (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_data_in),
    .out_valid_out (tq_valid),
    .out_ready_in  (tq_pop),
    .out_data_out  (tq_data)
  );

  link_fifo #(.WIDTH(link_pkg::WORD_W), .DEPTH(DEPTH)) rx_q (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (rq_push),
    .in_ready_out  (rq_ready),
    .in_data_in    (rq_data),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  always_comb begin
    state_d = state_q;
    own_d   = own_q;
    ack_d   = 1'b0;
    strb_d  = 1'b0;
    rdy_d   = 1'b0;
    cnt_d   = cnt_q;
    word_d  = word_q;
    asm_d   = asm_q;
    tq_pop  = 1'b0;
    rq_push = 1'b0;
    // ask for the token only with data
    req_d   = !own_q && tq_valid && !ack_in;
    case (state_q)
      link_pkg::ST_IDLE: begin
        if (own_q) begin
          if (req_in) begin
            ack_d = 1'b1;
            own_d = 1'b0;
          end else if (tq_valid) begin
            tq_pop  = 1'b1;
            word_d  = tq_data;
            strb_d  = 1'b1;
            state_d = link_pkg::ST_TREQ;
          end
        end else if (ack_in && !ack_q) begin
          // in the grant cycle the acknowledge on the line is our own; only the far one counts
          // take over the token
          own_d = 1'b1;
        end else if (strb_in && rq_ready) begin
          rdy_d   = 1'b1;
          state_d = link_pkg::ST_RACK;
        end
      end
      link_pkg::ST_TREQ: begin
        strb_d = 1'b1;
        if (rdy_in) begin
          cnt_d   = link_pkg::CNT_RESET;
          state_d = link_pkg::ST_TBYTE;
        end
      end
      link_pkg::ST_TBYTE: begin
        word_d = word_q >> link_pkg::BYTE_W;
        cnt_d  = cnt_q + 1'b1;
        if (cnt_q == link_pkg::LAST_BYTE) begin
          state_d = link_pkg::ST_IDLE;
        end else begin
          strb_d = 1'b1;
        end
      end
      link_pkg::ST_RACK: begin
        cnt_d   = link_pkg::CNT_RESET;
        state_d = link_pkg::ST_RBYTE;
      end
      link_pkg::ST_RBYTE: begin
        if (strb_in) begin
          asm_d = rq_data[link_pkg::WORD_W-1:link_pkg::BYTE_W];
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == link_pkg::LAST_BYTE) begin
            rq_push = 1'b1;
            state_d = link_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = link_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= link_pkg::ST_IDLE;
      own_q   <= OWNS_AT_RESET;
      req_q   <= 1'b0;
      ack_q   <= 1'b0;
      strb_q  <= 1'b0;
      rdy_q   <= 1'b0;
      cnt_q   <= link_pkg::CNT_RESET;
      word_q  <= link_pkg::WORD_RESET;
      asm_q   <= '0;
    end else begin
      state_q <= state_d;
      own_q   <= own_d;
      req_q   <= req_d;
      ack_q   <= ack_d;
      strb_q  <= strb_d;
      rdy_q   <= rdy_d;
      cnt_q   <= cnt_d;
      word_q  <= word_d;
      asm_q   <= asm_d;
    end
  end

  // token owner drives ack, strobe and bus
  // the old owner stays off req and ready during its grant cycle to avoid a clash
  assign link.near_ctl_out[link_pkg::CTL_REQ]  = req_q;
  assign link.near_ctl_out[link_pkg::CTL_ACK]  = ack_q;
  assign link.near_ctl_out[link_pkg::CTL_STRB] = strb_q;
  assign link.near_ctl_out[link_pkg::CTL_RDY]  = rdy_q;
  assign link.near_ctl_oe[link_pkg::CTL_REQ]   = !own_q && !ack_q;
  assign link.near_ctl_oe[link_pkg::CTL_ACK]   = own_q || ack_q;
  assign link.near_ctl_oe[link_pkg::CTL_STRB]  = own_q;
  assign link.near_ctl_oe[link_pkg::CTL_RDY]   = !own_q && !ack_q;
  assign link.near_bus_out                     = word_q[link_pkg::BYTE_W-1:0];
  assign link.near_bus_oe                      = own_q;
endmodule

/* File: hw/link_port_far.sv */
// far end of the processor link port, the same logic as the near end
// assumes link_fifo from the near end file; starts without the token by default
`timescale 1ns/1ps
module link_port_far #(
  parameter int unsigned DEPTH         = link_pkg::FIFO_DEPTH,
  parameter bit          OWNS_AT_RESET = 1'b0
) (
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  link_if.far_end                          link,
  input  wire logic                        tx_valid_in,
  input  wire logic [link_pkg::WORD_W-1:0] tx_data_in,
  output logic                             tx_ready_out,
  output logic                             rx_valid_out,
  output logic [link_pkg::WORD_W-1:0]      rx_data_out,
  input  wire logic                        rx_ready_in
);
  localparam int unsigned AS_W = link_pkg::WORD_W - link_pkg::BYTE_W;

  link_pkg::link_state_e         state_q, state_d;
  logic                          own_q, own_d, req_q, req_d, ack_q, ack_d;
  logic                          strb_q, strb_d, rdy_q, rdy_d;
  logic [1:0]                    cnt_q, cnt_d;
  logic [link_pkg::WORD_W-1:0]   word_q, word_d, tq_data, rq_data;
  logic [AS_W-1:0]               asm_q, asm_d;
  logic                          tq_valid, tq_pop, rq_push, rq_ready;
  logic                          req_in, ack_in, strb_in, rdy_in;

  assign req_in  = link.ctl[link_pkg::CTL_REQ];
  assign ack_in  = link.ctl[link_pkg::CTL_ACK];
  assign strb_in = link.ctl[link_pkg::CTL_STRB];
  assign rdy_in  = link.ctl[link_pkg::CTL_RDY];
  assign rq_data = {link.bus, asm_q};

  link_fifo #(.WIDTH(link_pkg::WORD_W), .DEPTH(DEPTH)) tx_q (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_data_in),
    .out_valid_out (tq_valid),
    .out_ready_in  (tq_pop),
    .out_data_out  (tq_data)
  );

  link_fifo #(.WIDTH(link_pkg::WORD_W), .DEPTH(DEPTH)) rx_q (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (rq_push),
    .in_ready_out  (rq_ready),
    .in_data_in    (rq_data),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  always_comb begin
    state_d = state_q;
    own_d   = own_q;
    ack_d   = 1'b0;
    strb_d  = 1'b0;
    rdy_d   = 1'b0;
    cnt_d   = cnt_q;
    word_d  = word_q;
    asm_d   = asm_q;
    tq_pop  = 1'b0;
    rq_push = 1'b0;
    req_d   = !own_q && tq_valid && !ack_in;
    case (state_q)
      link_pkg::ST_IDLE: begin
        if (own_q) begin
          if (req_in) begin
            ack_d = 1'b1;
            own_d = 1'b0;
          end else if (tq_valid) begin
            tq_pop  = 1'b1;
            word_d  = tq_data;
            strb_d  = 1'b1;
            state_d = link_pkg::ST_TREQ;
          end
        end else if (ack_in && !ack_q) begin
          // take the token only from the other end's acknowledge
          own_d = 1'b1;
        end else if (strb_in && rq_ready) begin
          rdy_d   = 1'b1;
          state_d = link_pkg::ST_RACK;
        end
      end
      link_pkg::ST_TREQ: begin
        strb_d = 1'b1;
        if (rdy_in) begin
          cnt_d   = link_pkg::CNT_RESET;
          state_d = link_pkg::ST_TBYTE;
        end
      end
      link_pkg::ST_TBYTE: begin
        word_d = word_q >> link_pkg::BYTE_W;
        cnt_d  = cnt_q + 1'b1;
        if (cnt_q == link_pkg::LAST_BYTE) begin
          state_d = link_pkg::ST_IDLE;
        end else begin
          strb_d = 1'b1;
        end
      end
      link_pkg::ST_RACK: begin
        cnt_d   = link_pkg::CNT_RESET;
        state_d = link_pkg::ST_RBYTE;
      end
      link_pkg::ST_RBYTE: begin
        if (strb_in) begin
          asm_d = rq_data[link_pkg::WORD_W-1:link_pkg::BYTE_W];
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == link_pkg::LAST_BYTE) begin
            rq_push = 1'b1;
            state_d = link_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_d = link_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= link_pkg::ST_IDLE;
      own_q   <= OWNS_AT_RESET;
      req_q   <= 1'b0;
      ack_q   <= 1'b0;
      strb_q  <= 1'b0;
      rdy_q   <= 1'b0;
      cnt_q   <= link_pkg::CNT_RESET;
      word_q  <= link_pkg::WORD_RESET;
      asm_q   <= '0;
    end else begin
      state_q <= state_d;
      own_q   <= own_d;
      req_q   <= req_d;
      ack_q   <= ack_d;
      strb_q  <= strb_d;
      rdy_q   <= rdy_d;
      cnt_q   <= cnt_d;
      word_q  <= word_d;
      asm_q   <= asm_d;
    end
  end

  // drive only the lines of the current role
  assign link.far_ctl_out[link_pkg::CTL_REQ]  = req_q;
  assign link.far_ctl_out[link_pkg::CTL_ACK]  = ack_q;
  assign link.far_ctl_out[link_pkg::CTL_STRB] = strb_q;
  assign link.far_ctl_out[link_pkg::CTL_RDY]  = rdy_q;
  assign link.far_ctl_oe[link_pkg::CTL_REQ]   = !own_q && !ack_q;
  assign link.far_ctl_oe[link_pkg::CTL_ACK]   = own_q || ack_q;
  assign link.far_ctl_oe[link_pkg::CTL_STRB]  = own_q;
  assign link.far_ctl_oe[link_pkg::CTL_RDY]   = !own_q && !ack_q;
  assign link.far_bus_out                     = word_q[link_pkg::BYTE_W-1:0];
  assign link.far_bus_oe                      = own_q;
endmodule

/* File: tb/link_checker.sv */
// concurrent checks on the control lines and byte bus shared by the two link port ends
// assumes one clock and a synchronous active-low reset common to both ends
`timescale 1ns/1ps
module link_checker (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire logic [link_pkg::CTL_W-1:0] near_ctl_oe,
  input  wire logic [link_pkg::CTL_W-1:0] far_ctl_oe,
  input  wire logic                       near_bus_oe,
  input  wire logic                       far_bus_oe,
  input  wire logic [link_pkg::CTL_W-1:0] ctl
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  bus_single_driver_a : assert property (
    !(near_bus_oe && far_bus_oe)) else $error("both ends drive the byte bus");
  ack_single_driver_a : assert property (
    $onehot({near_ctl_oe[link_pkg::CTL_ACK], far_ctl_oe[link_pkg::CTL_ACK]}))
    else $error("acknowledge line not driven by exactly one end");
  request_released_a : assert property (
    ctl[link_pkg::CTL_ACK] |=> !ctl[link_pkg::CTL_REQ])
    else $error("request still high after the token was granted");
  ack_after_request_a : assert property (
    $rose(ctl[link_pkg::CTL_ACK]) |-> $past(ctl[link_pkg::CTL_REQ]))
    else $error("acknowledge without a request");
  ack_one_cycle_a : assert property (
    ctl[link_pkg::CTL_ACK] |=> !ctl[link_pkg::CTL_ACK])
    else $error("acknowledge longer than one cycle");
  ready_after_strobe_a : assert property (
    $rose(ctl[link_pkg::CTL_RDY]) |-> $past(ctl[link_pkg::CTL_STRB]) && ctl[link_pkg::CTL_STRB])
    else $error("ready without a pending strobe");
  ready_one_cycle_a : assert property (
    ctl[link_pkg::CTL_RDY] |=> !ctl[link_pkg::CTL_RDY])
    else $error("ready longer than one cycle");
  four_byte_strobe_a : assert property (
    $rose(ctl[link_pkg::CTL_RDY]) |=> ctl[link_pkg::CTL_STRB] [*4] ##1 !ctl[link_pkg::CTL_STRB])
    else $error("strobe not held for exactly four byte cycles");
endmodule

/* File: tb/tb_byte_wide_processor_link_port.sv */
// self-checking bench: two link port ends joined through one link interface
// assumes link_pkg, link_if, link_fifo, both ends and link_checker are compiled first
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_byte_wide_processor_link_port;
  localparam int unsigned DEPTH = link_pkg::FIFO_DEPTH;
  localparam int          LIMIT = 500;
  logic                        clock_in;
  logic                        rst_n_in;
  logic [1:0]                  tx_valid;
  logic [1:0]                  tx_ready;
  logic [1:0]                  rx_valid;
  logic [1:0]                  rx_ready;
  logic [link_pkg::WORD_W-1:0] tx_data [2];
  logic [link_pkg::WORD_W-1:0] rx_data [2];
  logic [link_pkg::WORD_W-1:0] wire_q [$];
  logic [link_pkg::WORD_W-1:0] exp_q [$];
  logic [link_pkg::WORD_W-1:0] shift_q;
  logic [2:0]                  byte_cnt;
  int                          fails;
  int                          cmp_count;

  link_if link ();
  link_port_near #(.DEPTH(DEPTH), .OWNS_AT_RESET(1'b1)) i_link_port_near (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link(link),
    .tx_valid_in(tx_valid[0]), .tx_data_in(tx_data[0]), .tx_ready_out(tx_ready[0]),
    .rx_valid_out(rx_valid[0]), .rx_data_out(rx_data[0]), .rx_ready_in(rx_ready[0]));
  link_port_far #(.DEPTH(DEPTH), .OWNS_AT_RESET(1'b0)) i_link_port_far (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link(link),
    .tx_valid_in(tx_valid[1]), .tx_data_in(tx_data[1]), .tx_ready_out(tx_ready[1]),
    .rx_valid_out(rx_valid[1]), .rx_data_out(rx_data[1]), .rx_ready_in(rx_ready[1]));
  link_checker i_link_checker (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .near_ctl_oe(link.near_ctl_oe),
    .far_ctl_oe(link.far_ctl_oe), .near_bus_oe(link.near_bus_oe),
    .far_bus_oe(link.far_bus_oe), .ctl(link.ctl));

  // rebuild each word from the four bus bytes that follow a ready pulse
  always @(posedge clock_in) begin
    if (rst_n_in !== 1'b1) begin
      byte_cnt <= 3'h0;
    end else if (byte_cnt != 3'h0) begin
      shift_q  <= {link.bus, shift_q[31:8]};
      byte_cnt <= byte_cnt - 3'h1;
      if (byte_cnt == 3'h1) wire_q.push_back({link.bus, shift_q[31:8]});
    end else if (link.ctl[link_pkg::CTL_RDY] === 1'b1) begin
      byte_cnt <= 3'h4;
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n > LIMIT) begin
      fails++;
      $display("ERROR t=%0t wait expired", $time);
      end_sim();
    end
  endtask

  // valid is held until ready was seen in the cycle before the taking edge
  task automatic wr(input int s, input logic [31:0] w);
    int n;
    n = 0;
    @(posedge clock_in);
    tx_valid[s] <= 1'b1;
    tx_data[s]  <= w;
    do begin
      @(negedge clock_in);
      n++;
      hang(n);
    end while (tx_ready[s] !== 1'b1);
    @(posedge clock_in);
    tx_valid[s] <= 1'b0;
  endtask

  task automatic rd(input int s, input logic [31:0] w);
    int n;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
      hang(n);
    end while (rx_valid[s] !== 1'b1);
    `CHECK(rx_data[s], w)
    @(posedge clock_in);
    rx_ready[s] <= 1'b1;
    @(posedge clock_in);
    rx_ready[s] <= 1'b0;
  endtask

  task automatic wire_cmp();
    `CHECK(wire_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHECK(wire_q[i], exp_q[i])
    wire_q = {};
    exp_q  = {};
  endtask

  function automatic logic [31:0] pat(input int i);
    return 32'hA5C3_0F00 ^ {8'(i), 8'(i * 3), 8'(~i), 8'(i + 7)};
  endfunction

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  initial begin
    rst_n_in   = 1'b0;
    tx_valid   = 2'b00;
    rx_ready   = 2'b00;
    tx_data[0] = 32'h0000_0000;
    tx_data[1] = 32'h0000_0000;
    fails      = 0;
    cmp_count  = 0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (10) @(negedge clock_in);
    `CHECK(tx_ready, 2'b11)
    `CHECK(rx_valid, 2'b00)
    `CHECK(link.ctl, 4'h0)
    `CHECK(link.bus, 8'h00)
    $display("test reset done");
    // far never reads: its queue fills, one word waits unacknowledged, near queue fills
    for (int i = 0; i < 2 * DEPTH + 1; i++) begin
      exp_q.push_back(pat(i));
      wr(0, pat(i));
    end
    repeat (20) @(negedge clock_in);
    `CHECK(tx_ready[0], 1'b0)
    `CHECK(wire_q.size(), int'(DEPTH))
    @(posedge clock_in);
    tx_valid[0] <= 1'b1;
    tx_data[0]  <= 32'hFFFF_0000;
    repeat (3) @(posedge clock_in);
    tx_valid[0] <= 1'b0;
    @(negedge clock_in);
    `CHECK(tx_ready[0], 1'b0)
    foreach (exp_q[i]) rd(1, exp_q[i]);
    repeat (20) @(negedge clock_in);
    `CHECK(rx_valid[1], 1'b0)
    wire_cmp();
    $display("test fill and drain done");
    // both ends offer a word in the same cycle; the token decides the order
    fork
      wr(0, 32'h1234_5678);
      wr(1, 32'h8765_4321);
    join
    rd(1, 32'h1234_5678);
    rd(0, 32'h8765_4321);
    `CHECK(wire_q.size(), 2)
    // the near end holds the token, so its word crosses first
    `CHECK(wire_q[0], 32'h1234_5678)
    `CHECK(wire_q[1], 32'h8765_4321)
    wire_q = {};
    $display("test contention done");
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(pat(40 + i));
      wr(1, pat(40 + i));
    end
    for (int i = 0; i < 3; i++) rd(0, pat(40 + i));
    exp_q.push_back(pat(50));
    wr(0, pat(50));
    rd(1, pat(50));
    wire_cmp();
    $display("test token return done");
    end_sim();
  end
endmodule
